// ### logic/rcsp_map.vh
// Offsets, field positions, codes and timing constants of the panel logic.
`ifndef RCSP_MAP_VH
`define RCSP_MAP_VH

// ----------
// Register word indices (byte address bits 4:2).
// ----------
`define RCSP_IDX_CTRL 3'h0
`define RCSP_IDX_STATUS 3'h1
`define RCSP_IDX_LAMPS 3'h2
`define RCSP_IDX_RXPWR 3'h3

// ----------
// Control register fields and reset value.
// ----------
`define RCSP_CTRL_RATE_LSB 0
`define RCSP_CTRL_RATE_MSB 2
`define RCSP_CTRL_MUTE_BIT 3
`define RCSP_CTRL_NOEQ_BIT 4
`define RCSP_CTRL_RESET 5'h00

// ----------
// Reclocker rate settings, in button order.
// ----------
`define RCSP_MODE_AUTO 3'h0
`define RCSP_MODE_BYPASS 3'h1
`define RCSP_MODE_SD 3'h2
`define RCSP_MODE_HD 3'h3
`define RCSP_MODE_TOP 3'h4

// ----------
// Rate reported by the reclocker detector.
// ----------
`define RCSP_DET_NONE 2'h0
`define RCSP_DET_SD 2'h1
`define RCSP_DET_HD 2'h2
`define RCSP_DET_TOP 2'h3

// ----------
// Boot state reported by the card processor.
// ----------
`define RCSP_BOOT_POWERON 2'h0
`define RCSP_BOOT_CPU 2'h1
`define RCSP_BOOT_LOADER 2'h2
`define RCSP_BOOT_RUN 2'h3

// ----------
// Receive power thresholds in dBm, two's complement.
// ----------
`define RCSP_RXTH_0 8'hfa
`define RCSP_RXTH_1 8'hf7
`define RCSP_RXTH_2 8'hf4
`define RCSP_RXTH_3 8'hf1
`define RCSP_RXTH_4 8'hee

// ----------
// Timing.
// ----------
`define RCSP_CLK_KHZ 50000
`define RCSP_DEBOUNCE_MS 10
`define RCSP_FLASH_MS 250

`endif

// ### logic/rcsp_panel.v
// Card-edge control, remote register access and lamp drive of the converter.
`timescale 1ns/1ns
`include "rcsp_map.vh"
// Contract
// - Remote config: remote sets all, button works, jumpers ignored.
// - Local-only, default: remote writes dropped, local controls used.
// - Local-only still lets the remote read status and configuration.
// - Loss-mute jumper is used only under local-only configuration.
// - Mute selected: silence outputs on no signal, or on no reclocker lock outside bypass.
// - Default no-mute keeps outputs active on loss of input or lock.
// - Electrical-to-optical bypass: jumper switches the equalizer.
// - Each press steps auto, bypass, fixed SD, fixed HD, fixed 3G.
// - Auto mode detects the input rate and locks to any supported rate.
// - Bypass passes any rate unreclocked; HD slew unless valid SD input.
// - Fixed settings reclock only at that rate with auto detection off.
// - Power lamp: green run, flash loader, yellow CPU boot, red fault.
// - Input lamp green with valid input, red without.
// - Lock lamp green locked, red unlocked, off in bypass.
// - Auto lamp only in auto; manual lamp for fixed rate or bypass.
// - Bypass lamp only when bypass is selected.
// - Rate lamp lights for its fixed setting or auto locked at that rate.
// - Spare rate lamp always dark.
// - Electrical-to-optical: fiber lamp green normal, red on fault.
// - Optical-to-electrical variant drives five receive power lamps.
// - Bar graph thresholds -6 to -18 dBm; lamp lit above its threshold.
module rcsp_panel #(
   parameter DEBOUNCE_CYC = `RCSP_DEBOUNCE_MS * `RCSP_CLK_KHZ,
   parameter FLASH_CYC = `RCSP_FLASH_MS * `RCSP_CLK_KHZ
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Avalon-MM slave
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // Card-edge jumpers and button, asynchronous pins
   input wire config_source_jumper,
   input wire loss_mute_jumper,
   input wire cable_comp_bypass_jumper,
   input wire rate_select_button,
   input wire variant_eo_strap,
   // Reclocker, equalizer and optics status, asynchronous pins
   input wire eq_signal_detect,
   input wire reclocker_lock,
   input wire [1:0] reclocker_det_rate,
   input wire optic_tx_fault,
   // Same-clock status from the processor and optical module logic
   input wire [1:0] boot_state,
   input wire card_fault,
   input wire [7:0] rx_power_dbm,
   // Reclocker and equalizer control
   output reg reclock_enable,
   output reg auto_detect_enable,
   output reg [1:0] fixed_rate_sel,
   output reg sd_slew_sel,
   output reg cable_comp_enable,
   output reg output_mute,
   // Lamps
   output reg supply_health_lamp_green,
   output reg supply_health_lamp_red,
   output reg input_lamp_green,
   output reg input_lamp_red,
   output reg lock_lamp_green,
   output reg lock_lamp_red,
   output reg auto_lamp,
   output reg manual_lamp,
   output reg bypass_lamp,
   output reg spare_lamp,
   output reg sd_lamp,
   output reg hd_lamp,
   output reg top_lamp,
   output reg fiber_lamp_green,
   output reg fiber_lamp_red,
   output reg [4:0] rx_power_lamp
);

   localparam [23:0] DEB_LIM = DEBOUNCE_CYC - 1;
   localparam [23:0] FLASH_LIM = FLASH_CYC - 1;
   localparam NSYNC = 11;

   // ----------------------------------------------------------------------
   // Functions.
   // ----------------------------------------------------------------------
   function rate_lamp;
      input [2:0] mode;
      input [2:0] fixed;
      input lock;
      input [1:0] det;
      input [1:0] want;
      begin
         rate_lamp = (mode == fixed) ||
            ((mode == `RCSP_MODE_AUTO) && lock && (det == want));
      end
   endfunction

   function [7:0] rx_thresh;
      input integer i;
      begin
         case (i)
            0: rx_thresh = `RCSP_RXTH_0;
            1: rx_thresh = `RCSP_RXTH_1;
            2: rx_thresh = `RCSP_RXTH_2;
            3: rx_thresh = `RCSP_RXTH_3;
            default: rx_thresh = `RCSP_RXTH_4;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // Two-stage synchronisers for the asynchronous pins.
   // ----------------------------------------------------------------------
   wire [NSYNC-1:0] pin_raw;
   reg [NSYNC-1:0] pin_meta_r;
   reg [NSYNC-1:0] pin_sync_r;
   assign pin_raw = {optic_tx_fault, reclocker_det_rate, reclocker_lock,
      eq_signal_detect, variant_eo_strap, rate_select_button,
      cable_comp_bypass_jumper, loss_mute_jumper, config_source_jumper,
      1'b0};

   genvar g;
   generate
      for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               pin_meta_r[g] <= 1'b0;
               pin_sync_r[g] <= 1'b0;
            end else begin
               pin_meta_r[g] <= pin_raw[g];
               pin_sync_r[g] <= pin_meta_r[g];
            end
         end
      end
   endgenerate

   wire remote_cfg = pin_sync_r[1];
   wire mute_jmp = pin_sync_r[2];
   wire noeq_jmp = pin_sync_r[3];
   wire button_lvl = pin_sync_r[4];
   wire is_eo = pin_sync_r[5];
   wire sig_det = pin_sync_r[6];
   wire rc_lock = pin_sync_r[7];
   wire [1:0] det_rate = pin_sync_r[9:8];
   wire tx_fault = pin_sync_r[10];

   // ----------------------------------------------------------------------
   // Button debounce and press pulse.
   // ----------------------------------------------------------------------
   reg [23:0] deb_cnt_r;
   reg btn_db_r;
   reg press_r;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         deb_cnt_r <= 24'h000000;
         btn_db_r <= 1'b0;
         press_r <= 1'b0;
      end else begin
         press_r <= 1'b0;
         if (button_lvl == btn_db_r) begin
            deb_cnt_r <= 24'h000000;
         end else if (deb_cnt_r >= DEB_LIM) begin
            deb_cnt_r <= 24'h000000;
            btn_db_r <= button_lvl;
            press_r <= button_lvl;
         end else begin
            deb_cnt_r <= deb_cnt_r + 24'h000001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Avalon-MM slave and configuration register.
   // ----------------------------------------------------------------------
   reg [2:0] mode_r;
   reg reg_mute_r;
   reg reg_noeq_r;
   wire [2:0] widx = avs_address[4:2];
   wire wr_go = avs_write && !avs_waitrequest;
   wire [2:0] mode_step = (mode_r == `RCSP_MODE_TOP) ? `RCSP_MODE_AUTO :
      mode_r + 3'h1;
   wire [2:0] wr_mode =
      avs_writedata[`RCSP_CTRL_RATE_MSB:`RCSP_CTRL_RATE_LSB];

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_r <= `RCSP_MODE_AUTO;
         reg_mute_r <= 1'b0;
         reg_noeq_r <= 1'b0;
      end else if (press_r) begin
         mode_r <= mode_step;
      end else if (wr_go && remote_cfg && (widx == `RCSP_IDX_CTRL)) begin
         // Local-only configuration drops the write.
         if (wr_mode <= `RCSP_MODE_TOP) begin
            mode_r <= wr_mode;
         end
         reg_mute_r <= avs_writedata[`RCSP_CTRL_MUTE_BIT];
         reg_noeq_r <= avs_writedata[`RCSP_CTRL_NOEQ_BIT];
      end
   end

   reg [31:0] rd_word;
   always @* begin
      rd_word = 32'h00000000;
      case (widx)
         `RCSP_IDX_CTRL: begin
            rd_word[4:0] = {reg_noeq_r, reg_mute_r, mode_r};
         end
         `RCSP_IDX_STATUS: begin
            rd_word[9:0] = {output_mute, is_eo, noeq_jmp, mute_jmp,
               remote_cfg, tx_fault, det_rate, rc_lock, sig_det};
         end
         `RCSP_IDX_LAMPS: begin
            rd_word[15:0] = {supply_health_lamp_green,
               supply_health_lamp_red, input_lamp_green, input_lamp_red,
               lock_lamp_green, lock_lamp_red, auto_lamp, manual_lamp,
               bypass_lamp, spare_lamp, sd_lamp, hd_lamp, top_lamp,
               fiber_lamp_green, fiber_lamp_red, 1'b0};
         end
         `RCSP_IDX_RXPWR: begin
            rd_word[12:0] = {rx_power_lamp, rx_power_dbm};
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= avs_read ? rd_word : 32'h00000000;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Effective settings.
   // ----------------------------------------------------------------------
   wire mute_sel = remote_cfg ? reg_mute_r : mute_jmp;
   wire noeq_sel = remote_cfg ? reg_noeq_r : noeq_jmp;
   wire in_bypass = (mode_r == `RCSP_MODE_BYPASS);
   wire in_auto = (mode_r == `RCSP_MODE_AUTO);
   wire lost = !sig_det || (!in_bypass && !rc_lock);

   // ----------------------------------------------------------------------
   // Flash divider for the supply lamp.
   // ----------------------------------------------------------------------
   reg [23:0] flash_cnt_r;
   reg flash_r;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         flash_cnt_r <= 24'h000000;
         flash_r <= 1'b0;
      end else if (flash_cnt_r >= FLASH_LIM) begin
         flash_cnt_r <= 24'h000000;
         flash_r <= !flash_r;
      end else begin
         flash_cnt_r <= flash_cnt_r + 24'h000001;
      end
   end

   // ----------------------------------------------------------------------
   // Receive power bar graph.
   // ----------------------------------------------------------------------
   wire [4:0] rx_bar;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_rxbar
         assign rx_bar[g] = !is_eo &&
            ($signed(rx_power_dbm) > $signed(rx_thresh(g)));
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Registered control outputs and lamps.
   // ----------------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         reclock_enable <= 1'b1;
         auto_detect_enable <= 1'b1;
         fixed_rate_sel <= `RCSP_DET_NONE;
         sd_slew_sel <= 1'b0;
         cable_comp_enable <= 1'b1;
         output_mute <= 1'b0;
         supply_health_lamp_green <= 1'b0;
         supply_health_lamp_red <= 1'b1;
         input_lamp_green <= 1'b0;
         input_lamp_red <= 1'b0;
         lock_lamp_green <= 1'b0;
         lock_lamp_red <= 1'b0;
         auto_lamp <= 1'b0;
         manual_lamp <= 1'b0;
         bypass_lamp <= 1'b0;
         spare_lamp <= 1'b0;
         sd_lamp <= 1'b0;
         hd_lamp <= 1'b0;
         top_lamp <= 1'b0;
         fiber_lamp_green <= 1'b0;
         fiber_lamp_red <= 1'b0;
         rx_power_lamp <= 5'h00;
      end else begin
         reclock_enable <= !in_bypass;
         auto_detect_enable <= in_auto;
         case (mode_r)
            `RCSP_MODE_SD: fixed_rate_sel <= `RCSP_DET_SD;
            `RCSP_MODE_HD: fixed_rate_sel <= `RCSP_DET_HD;
            `RCSP_MODE_TOP: fixed_rate_sel <= `RCSP_DET_TOP;
            default: fixed_rate_sel <= `RCSP_DET_NONE;
         endcase
         if (in_bypass) begin
            sd_slew_sel <= sig_det && (det_rate == `RCSP_DET_SD);
         end else begin
            sd_slew_sel <= rate_lamp(mode_r, `RCSP_MODE_SD, rc_lock,
               det_rate, `RCSP_DET_SD);
         end
         cable_comp_enable <= !(is_eo && in_bypass && noeq_sel);
         output_mute <= mute_sel && lost;
         case (boot_state)
            `RCSP_BOOT_RUN: begin
               supply_health_lamp_green <= !card_fault;
               supply_health_lamp_red <= card_fault;
            end
            `RCSP_BOOT_LOADER: begin
               supply_health_lamp_green <= flash_r && !card_fault;
               supply_health_lamp_red <= card_fault;
            end
            `RCSP_BOOT_CPU: begin
               supply_health_lamp_green <= 1'b1;
               supply_health_lamp_red <= 1'b1;
            end
            default: begin
               supply_health_lamp_green <= 1'b0;
               supply_health_lamp_red <= 1'b1;
            end
         endcase
         input_lamp_green <= sig_det;
         input_lamp_red <= !sig_det;
         lock_lamp_green <= !in_bypass && rc_lock;
         lock_lamp_red <= !in_bypass && !rc_lock;
         auto_lamp <= in_auto;
         manual_lamp <= !in_auto;
         bypass_lamp <= in_bypass;
         spare_lamp <= 1'b0;
         sd_lamp <= rate_lamp(mode_r, `RCSP_MODE_SD, rc_lock, det_rate,
            `RCSP_DET_SD);
         hd_lamp <= rate_lamp(mode_r, `RCSP_MODE_HD, rc_lock, det_rate,
            `RCSP_DET_HD);
         top_lamp <= rate_lamp(mode_r, `RCSP_MODE_TOP, rc_lock, det_rate,
            `RCSP_DET_TOP);
         fiber_lamp_green <= is_eo && !tx_fault;
         fiber_lamp_red <= is_eo && tx_fault;
         rx_power_lamp <= rx_bar;
      end
   end

endmodule // rcsp_panel

// ### sim/rcsp_panel_props.sv
// Concurrent checks on the ports of the panel logic.
`timescale 1ns/1ns
`include "rcsp_map.vh"
module rcsp_panel_props (
   // Clock, reset and bus
   input logic clk,
   input logic rst,
   input logic avs_read,
   input logic avs_write,
   input logic avs_waitrequest,
   // Status pins
   input logic eq_signal_detect,
   input logic reclocker_lock,
   input logic optic_tx_fault,
   input logic [1:0] boot_state,
   input logic card_fault,
   input logic [7:0] rx_power_dbm,
   // Controls and lamps
   input logic reclock_enable,
   input logic auto_detect_enable,
   input logic [1:0] fixed_rate_sel,
   input logic output_mute,
   input logic supply_health_lamp_green,
   input logic supply_health_lamp_red,
   input logic input_lamp_green,
   input logic input_lamp_red,
   input logic lock_lamp_green,
   input logic lock_lamp_red,
   input logic auto_lamp,
   input logic manual_lamp,
   input logic bypass_lamp,
   input logic spare_lamp,
   input logic fiber_lamp_red,
   input logic [4:0] rx_power_lamp
);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Counts cycles after reset so that pin history is valid.
   logic [2:0] warm_r;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         warm_r <= 3'h0;
      end else if (warm_r != 3'h7) begin
         warm_r <= warm_r + 3'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   sequence s_running;
      (boot_state == `RCSP_BOOT_RUN && !card_fault) [*3];
   endsequence
   sequence s_faulted;
      (boot_state == `RCSP_BOOT_RUN && card_fault) [*3];
   endsequence
   chk_bus_answer: assert property (s_req |=> s_ans)
      else $error("bus answer not one cycle after request");
   chk_supply_green: assert property (s_running |->
      supply_health_lamp_green && !supply_health_lamp_red)
      else $error("supply lamp not green while running");
   chk_supply_fault: assert property (s_faulted |->
      supply_health_lamp_red && !supply_health_lamp_green)
      else $error("supply lamp not red on fault");
   chk_spare_dark: assert property (spare_lamp == 1'b0)
      else $error("spare lamp lit");
   chk_auto_lamp: assert property (auto_lamp |->
      auto_detect_enable && !manual_lamp)
      else $error("auto lamp without auto detection");
   chk_manual_lamp: assert property (manual_lamp |->
      !auto_detect_enable && !auto_lamp)
      else $error("manual lamp with auto detection");
   chk_bypass_lamp: assert property (bypass_lamp |->
      !reclock_enable && manual_lamp && fixed_rate_sel == 2'h0)
      else $error("bypass lamp while reclocking");
   chk_fixed_rate: assert property (fixed_rate_sel != 2'h0 |->
      reclock_enable && !auto_detect_enable)
      else $error("fixed rate with auto detection");
   chk_lock_off: assert property (!reclock_enable |->
      !lock_lamp_green && !lock_lamp_red)
      else $error("lock lamp lit in bypass");
   chk_mute_cause: assert property (warm_r == 3'h7 && output_mute |->
      !$past(eq_signal_detect, 3) || !$past(reclocker_lock, 3))
      else $error("mute without loss of signal or lock");
   chk_input_lamp: assert property (warm_r == 3'h7 |->
      input_lamp_green == $past(eq_signal_detect, 3) &&
      input_lamp_red == !$past(eq_signal_detect, 3))
      else $error("input lamp does not follow detect");
   chk_fiber_red: assert property (warm_r == 3'h7 && fiber_lamp_red |->
      $past(optic_tx_fault, 3))
      else $error("fiber lamp red without fault");
   chk_rx_bar: assert property (rx_power_lamp[0] |->
      $signed($past(rx_power_dbm)) > $signed(`RCSP_RXTH_0))
      else $error("top power lamp lit at or below threshold");
endmodule // rcsp_panel_props
bind rcsp_panel rcsp_panel_props props_u (.*);

// ### sim/rcsp_operator.sv
// Card-edge operator model: jumpers and the rate button.
`timescale 1ns/1ns
module rcsp_operator (
   // Clock
   input logic clk,
   // Card-edge controls
   output logic config_source_jumper,
   output logic loss_mute_jumper,
   output logic cable_comp_bypass_jumper,
   output logic rate_select_button
);
   // ----------------------------------------------------------------
   // Operator actions
   // ----------------------------------------------------------------
   initial begin
      config_source_jumper = 1'b0;
      loss_mute_jumper = 1'b0;
      cable_comp_bypass_jumper = 1'b0;
      rate_select_button = 1'b0;
   end
   task set_jumpers(input logic src, input logic mute, input logic noeq);
      begin
         @(posedge clk);
         config_source_jumper <= src;
         loss_mute_jumper <= mute;
         cable_comp_bypass_jumper <= noeq;
      end
   endtask
   // A short hold acts as contact bounce and must not step the rate.
   task press(input int hold);
      begin
         @(posedge clk);
         rate_select_button <= 1'b1;
         repeat (hold) @(posedge clk);
         rate_select_button <= 1'b0;
         repeat (hold) @(posedge clk);
      end
   endtask
endmodule // rcsp_operator

// ### sim/rcsp_panel_tb_top.sv
// Self-checking bench for the panel logic.
`timescale 1ns/1ns
`include "rcsp_map.vh"
module rcsp_panel_tb_top;
   // ----------------------------------------------------------------
   // Bench
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic variant_eo_strap = 1'b1;
   logic eq_signal_detect = 1'b1;
   logic reclocker_lock = 1'b1;
   logic [1:0] reclocker_det_rate = `RCSP_DET_HD;
   logic optic_tx_fault = 1'b0;
   logic [1:0] boot_state = `RCSP_BOOT_RUN;
   logic card_fault = 1'b0;
   logic [7:0] rx_power_dbm = 8'hfd;
   wire [31:0] avs_readdata;
   wire [1:0] fixed_rate_sel;
   wire [4:0] rx_power_lamp;
   wire avs_waitrequest, config_source_jumper, loss_mute_jumper;
   wire cable_comp_bypass_jumper, rate_select_button, reclock_enable;
   wire auto_detect_enable, sd_slew_sel, cable_comp_enable, output_mute;
   wire supply_health_lamp_green, supply_health_lamp_red, input_lamp_green;
   wire input_lamp_red, lock_lamp_green, lock_lamp_red, auto_lamp;
   wire manual_lamp, bypass_lamp, spare_lamp, sd_lamp, hd_lamp, top_lamp;
   wire fiber_lamp_green, fiber_lamp_red;
   int mismatches = 0;
   int samples_checked = 0;
   int cyc = 0;
   int i;
   logic [31:0] rd;
   logic [1:0] seen;
   logic [9:0] mode_tbl [5] = '{10'h262, 10'h180, 10'h14c, 10'h152, 10'h159};
   logic [1:0] sup_tbl [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
   logic [7:0] rx_tbl [6] = '{8'hfd, 8'hfa, 8'hf6, 8'hf2, 8'hee, 8'h80};
   logic [4:0] rx_exp [6] = '{5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h00, 5'h00};
   rcsp_panel #(.DEBOUNCE_CYC(4), .FLASH_CYC(8)) dut_u (.*);
   rcsp_operator op_u (.*);
   always #10 clk = ~clk;
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         samples_checked++;
         if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task settle;
      begin
         repeat (8) @(posedge clk);
         @(negedge clk);
      end
   endtask
   // Holds the request until waitrequest is seen low at a rising edge.
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         avs_address <= a;
         avs_writedata <= d;
         avs_write <= wr;
         avs_read <= !wr;
         do @(posedge clk); while (avs_waitrequest !== 1'b0);
         rd = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
      end
   endtask
   task chk_mode(input logic [9:0] e);
      chk("mode outputs", {22'h0, e}, {22'h0, auto_lamp, manual_lamp,
         bypass_lamp, reclock_enable, auto_detect_enable, fixed_rate_sel,
         sd_lamp, hd_lamp, top_lamp});
   endtask
   task t_defaults;
      begin
         settle;
         bus(1'b0, 5'h00, 32'h0);
         chk("ctrl reset", 32'h0, rd);
         chk("mute reset", 32'h0, {31'h0, output_mute});
         chk_mode(mode_tbl[0]);
         bus(1'b0, 5'h14, 32'h0);
         chk("unmapped read", 32'h0, rd);
         $display("test defaults done");
      end
   endtask
   task t_button;
      begin
         op_u.press(2);
         settle;
         chk_mode(mode_tbl[0]);
         for (i = 1; i <= 5; i++) begin
            op_u.press(12);
            settle;
            chk_mode(mode_tbl[i % 5]);
         end
         $display("test button done");
      end
   endtask
   task t_local;
      begin
         bus(1'b1, 5'h00, 32'h3);
         bus(1'b0, 5'h00, 32'h0);
         chk("ctrl local write", 32'h0, rd);
         bus(1'b0, 5'h04, 32'h0);
         chk("status read", 32'h0b, rd & 32'h2f);
         $display("test local done");
      end
   endtask
   task t_remote;
      begin
         op_u.set_jumpers(1'b1, 1'b1, 1'b1);
         settle;
         bus(1'b1, 5'h00, 32'h3);
         settle;
         chk_mode(mode_tbl[3]);
         bus(1'b1, 5'h00, 32'h7);
         bus(1'b0, 5'h00, 32'h0);
         chk("ctrl bad rate", 32'h3, rd);
         op_u.press(12);
         settle;
         chk_mode(mode_tbl[4]);
         bus(1'b1, 5'h00, 32'h0);
         @(posedge clk);
         eq_signal_detect <= 1'b0;
         settle;
         chk("jumper ignored", 32'h0, {31'h0, output_mute});
         bus(1'b1, 5'h00, 32'h8);
         settle;
         chk("remote mute", 32'h1, {31'h0, output_mute});
         @(posedge clk);
         eq_signal_detect <= 1'b1;
         reclocker_lock <= 1'b0;
         settle;
         chk("lock loss", 32'h5, {29'h0, output_mute, lock_lamp_green,
            lock_lamp_red});
         bus(1'b1, 5'h00, 32'h19);
         settle;
         chk("bypass eo", 32'h0, {28'h0, output_mute, lock_lamp_green,
            lock_lamp_red, cable_comp_enable});
         @(posedge clk);
         reclocker_det_rate <= `RCSP_DET_SD;
         variant_eo_strap <= 1'b0;
         settle;
         chk("bypass oe", 32'h3, {30'h0, sd_slew_sel,
            cable_comp_enable});
         @(posedge clk);
         reclocker_det_rate <= `RCSP_DET_HD;
         reclocker_lock <= 1'b1;
         variant_eo_strap <= 1'b1;
         settle;
         chk("hd slew", 32'h0, {31'h0, sd_slew_sel});
         bus(1'b1, 5'h00, 32'h0);
         $display("test remote done");
      end
   endtask
   task t_mute;
      begin
         op_u.set_jumpers(1'b0, 1'b0, 1'b0);
         @(posedge clk);
         eq_signal_detect <= 1'b0;
         settle;
         chk("no mute", 32'h1, {30'h0, output_mute,
            input_lamp_red});
         op_u.set_jumpers(1'b0, 1'b1, 1'b0);
         settle;
         chk("local mute", 32'h3, {30'h0, output_mute,
            input_lamp_red});
         @(posedge clk);
         eq_signal_detect <= 1'b1;
         settle;
         chk("signal back", 32'h1, {30'h0, output_mute,
            input_lamp_green});
         $display("test mute done");
      end
   endtask
   task t_lamps;
      begin
         for (i = 0; i < 4; i++) begin
            @(posedge clk);
            boot_state <= i[1:0];
            settle;
            if (i != 2) chk("supply lamp", {30'h0, sup_tbl[i]}, {30'h0,
               supply_health_lamp_green, supply_health_lamp_red});
         end
         @(posedge clk);
         boot_state <= `RCSP_BOOT_LOADER;
         seen = 2'h0;
         repeat (40) begin
            @(negedge clk);
            seen = seen | {supply_health_lamp_green, !supply_health_lamp_green};
         end
         chk("supply flash", 32'h3, {30'h0, seen});
         @(posedge clk);
         boot_state <= `RCSP_BOOT_RUN;
         card_fault <= 1'b1;
         optic_tx_fault <= 1'b1;
         settle;
         chk("fault lamp", 32'h1, {30'h0, supply_health_lamp_green,
            supply_health_lamp_red});
         chk("fiber fault", 32'h1, {30'h0, fiber_lamp_green,
            fiber_lamp_red});
         @(posedge clk);
         card_fault <= 1'b0;
         optic_tx_fault <= 1'b0;
         settle;
         chk("fiber ok", 32'h2, {30'h0, fiber_lamp_green,
            fiber_lamp_red});
         @(posedge clk);
         variant_eo_strap <= 1'b0;
         for (i = 0; i < 6; i++) begin
            @(posedge clk);
            rx_power_dbm <= rx_tbl[i];
            settle;
            chk("rx lamps", {27'h0, rx_exp[i]}, {27'h0,
               rx_power_lamp});
         end
         $display("test lamps done");
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         close_out;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_defaults;
      t_button;
      t_local;
      t_remote;
      t_mute;
      t_lamps;
      close_out;
   end
endmodule // rcsp_panel_tb_top
